// ===== fhbp_host_port.sv
// framer host bus port: 8-bit processor port into the register space
// assumes host pins synchronous to core_clk_in; register file outside
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// R1 - reset pin low then high returns registers to power-up and pio to inputs
// R2 - host holds reset pin low two or more active processor clock cycles
// R3 - internal power-on reset does the same initialisation as the pin
// R4 - system supplies a continuous system clock for internal timing
// R5 - host gives processor sampling clock between 8 and 36 MHz in sync mode
// R6 - sampling clock used only when timing strap is 1, else ignored
// R7 - timing strap 0: latches follow chip select, strobe, direction directly
// R8 - timing strap 1: sample selects and strobes on sampling clock rising edge
// R9 - bus strap 0: bus is data, address from pins, strobe is data strobe
// R10 - separate style: direction high is read, low is write
// R11 - bus strap 1: bus carries address and data, low address pins ignored
// R12 - multiplexed style: strobe is read strobe, direction is write strobe
// R13 - four-framer variant: eleven address bits separate, bits 10..8 multiplexed
// R14 - larger variants: twelve address bits separate, bits 11..8 multiplexed
// R15 - address latched on address strobe falling edge in every style
// R16 - chip select low enables decoding, high ends access and floats bus
// R17 - sixteen-framer variant has two chip selects, one per framer bank
// R18 - transfer acknowledge low while address strobe and chip select low
// R19 - interrupt pin low while any request pending, released when all serviced
// R20 - read data driven only while chip select and read strobe both active
module fhbp_host_port
  import fhbp_pkg::*;
#(
  parameter int FRAMER_COUNT = 16
)
(
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  input  wire logic                hw_reset_n_in,
  input  wire logic                proc_sample_clk_in,
  input  wire logic                timing_select_in,
  input  wire logic                bus_style_select_in,
  input  wire logic [ADDR_W-1:0]   addr_pins_in,
  input  wire logic [DATA_W-1:0]   ad_in,
  output logic      [DATA_W-1:0]   ad_out,
  output logic                     ad_oe_out,
  input  wire logic                addr_strobe_n_in,
  input  wire logic                data_or_read_strobe_n_in,
  input  wire logic                dir_or_write_strobe_n_in,
  input  wire logic [BANK_CNT-1:0] chip_sel_bank_n_in,
  output logic      [BANK_CNT-1:0] xfer_ack_n_out,
  output logic      [BANK_CNT-1:0] xfer_ack_n_oe_out,
  input  wire logic [BANK_CNT-1:0] irq_pending_in,
  output logic      [BANK_CNT-1:0] irq_n_out,
  output logic      [BANK_CNT-1:0] irq_n_oe_out,
  output logic      [ADDR_W-1:0]   reg_addr_out,
  output logic                     reg_bank_out,
  output logic      [DATA_W-1:0]   reg_wdata_out,
  output logic                     reg_wr_out,
  output logic                     reg_rd_out,
  input  wire logic [DATA_W-1:0]   reg_rdata_in,
  output logic                     regs_init_out
);

  // =========================================================
  // variant decode
  localparam int SEP_ADDR_W = (FRAMER_COUNT == SMALL_VARIANT) ? SEP_ADDR_W_SMALL
                                                             : ADDR_W;
  localparam logic [ADDR_W-1:0] SEP_MASK = ADDR_W'((1 << SEP_ADDR_W) - 1); // [R13] [R14]
  localparam logic [ADDR_W-1:0] MUX_MASK = SEP_MASK & ~ADDR_W'((1 << MUX_ADDR_LSB) - 1);
  localparam logic [BANK_CNT-1:0] BANK_USED =
    (FRAMER_COUNT == TWO_BANK_VARIANT) ? 2'h3 : 2'h1;

  // =========================================================
  // initialisation
  logic init_next;
  logic init_reg;

  always_comb
  begin
    init_next = rst_in | ~hw_reset_n_in; // [R1] [R3]
  end

  always_ff @(posedge core_clk_in)
  begin
    init_reg <= init_next;
  end

  assign regs_init_out = init_reg;

  // =========================================================
  // pin sampling
  logic                pclk_prev_reg;
  logic                pclk_prev_next;
  logic                sample_en;
  logic [BANK_CNT-1:0] samp_cs_n_reg;
  logic [BANK_CNT-1:0] samp_cs_n_next;
  logic                samp_ds_n_reg;
  logic                samp_ds_n_next;
  logic                samp_dir_reg;
  logic                samp_dir_next;
  logic [DATA_W-1:0]   samp_ad_reg;
  logic [DATA_W-1:0]   samp_ad_next;

  always_comb
  begin
    pclk_prev_next = proc_sample_clk_in & timing_select_in; // [R6]
    sample_en      = 1'b1; // [R7]
    if (timing_select_in)
    begin
      sample_en = proc_sample_clk_in & ~pclk_prev_reg; // [R8]
    end
    samp_cs_n_next = samp_cs_n_reg;
    samp_ds_n_next = samp_ds_n_reg;
    samp_dir_next  = samp_dir_reg;
    samp_ad_next   = samp_ad_reg;
    if (sample_en)
    begin
      samp_cs_n_next = chip_sel_bank_n_in | ~BANK_USED; // [R17]
      samp_ds_n_next = data_or_read_strobe_n_in;
      samp_dir_next  = dir_or_write_strobe_n_in;
      samp_ad_next   = ad_in;
    end
    if (init_reg)
    begin
      samp_cs_n_next = BANK_IDLE;
      samp_ds_n_next = 1'b1;
      samp_dir_next  = 1'b1;
      samp_ad_next   = DATA_RST;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    pclk_prev_reg <= pclk_prev_next;
    samp_cs_n_reg <= samp_cs_n_next;
    samp_ds_n_reg <= samp_ds_n_next;
    samp_dir_reg  <= samp_dir_next;
    samp_ad_reg   <= samp_ad_next;
  end

  // =========================================================
  // address latch
  logic              as_prev_reg;
  logic              as_prev_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;

  always_comb
  begin
    as_prev_next = addr_strobe_n_in;
    addr_next    = addr_reg;
    if (as_prev_reg & ~addr_strobe_n_in) // [R15]
    begin
      if (bus_style_select_in)
      begin
        addr_next = (addr_pins_in & MUX_MASK) | {{(ADDR_W-DATA_W){1'b0}}, ad_in}; // [R11]
      end
      else
      begin
        addr_next = addr_pins_in & SEP_MASK; // [R9]
      end
    end
    if (init_reg)
    begin
      as_prev_next = 1'b1;
      addr_next    = ADDR_RST;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    as_prev_reg <= as_prev_next;
    addr_reg    <= addr_next;
  end

  // =========================================================
  // access sequencer
  fhbp_state_e       state_reg;
  fhbp_state_e       state_next;
  logic              cs_act;
  logic              bank_sel;
  logic              rd_req;
  logic              wr_req;
  logic              bank_reg;
  logic              bank_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              oe_reg;
  logic              oe_next;
  logic              rd_pulse_reg;
  logic              rd_pulse_next;
  logic              wr_pulse_reg;
  logic              wr_pulse_next;
  logic [ADDR_W-1:0] raddr_reg;
  logic [ADDR_W-1:0] raddr_next;

  always_comb
  begin
    cs_act   = ~(&samp_cs_n_reg); // [R16]
    bank_sel = samp_cs_n_reg[0];
    if (bus_style_select_in)
    begin
      rd_req = cs_act & ~samp_ds_n_reg; // [R12]
      wr_req = cs_act & ~samp_dir_reg;
    end
    else
    begin
      rd_req = cs_act & ~samp_ds_n_reg & samp_dir_reg; // [R10]
      wr_req = cs_act & ~samp_ds_n_reg & ~samp_dir_reg;
    end
    state_next    = state_reg;
    bank_next     = bank_reg;
    wdata_next    = wdata_reg;
    rdata_next    = rdata_reg;
    raddr_next    = raddr_reg;
    rd_pulse_next = 1'b0;
    wr_pulse_next = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (rd_req)
        begin
          state_next    = ST_READ;
          bank_next     = bank_sel;
          raddr_next    = addr_reg;
          rd_pulse_next = 1'b1;
        end
        else if (wr_req)
        begin
          state_next = ST_WRITE;
          bank_next  = bank_sel;
          raddr_next = addr_reg;
          wdata_next = samp_ad_reg;
        end
      end
      ST_READ:
      begin
        rdata_next = reg_rdata_in;
        if (!rd_req)
        begin
          state_next = ST_IDLE; // [R16]
        end
      end
      ST_WRITE:
      begin
        if (wr_req)
        begin
          wdata_next = samp_ad_reg;
        end
        else
        begin
          state_next    = ST_IDLE;
          wr_pulse_next = 1'b1;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    oe_next = (state_next == ST_READ) & rd_req; // [R20]
    if (init_reg)
    begin
      state_next    = ST_IDLE; // [R1]
      bank_next     = 1'b0;
      wdata_next    = DATA_RST;
      rdata_next    = DATA_RST;
      raddr_next    = ADDR_RST;
      oe_next       = 1'b0;
      rd_pulse_next = 1'b0;
      wr_pulse_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    state_reg    <= state_next;
    bank_reg     <= bank_next;
    wdata_reg    <= wdata_next;
    rdata_reg    <= rdata_next;
    raddr_reg    <= raddr_next;
    oe_reg       <= oe_next;
    rd_pulse_reg <= rd_pulse_next;
    wr_pulse_reg <= wr_pulse_next;
  end

  assign ad_out        = rdata_reg;
  assign ad_oe_out     = oe_reg;
  assign reg_addr_out  = raddr_reg;
  assign reg_bank_out  = bank_reg;
  assign reg_wdata_out = wdata_reg;
  assign reg_rd_out    = rd_pulse_reg;
  assign reg_wr_out    = wr_pulse_reg;

  // =========================================================
  // per-bank open-drain outputs
  genvar b;
  generate
    for (b = 0; b < BANK_CNT; b++)
    begin : g_bank
      logic ack_oe_reg;
      logic ack_oe_next;
      logic irq_oe_reg;
      logic irq_oe_next;

      always_comb
      begin
        ack_oe_next = BANK_USED[b] & ~addr_strobe_n_in & ~chip_sel_bank_n_in[b]; // [R18]
        irq_oe_next = BANK_USED[b] & irq_pending_in[b]; // [R19]
        if (init_reg)
        begin
          ack_oe_next = 1'b0;
          irq_oe_next = 1'b0;
        end
      end

      always_ff @(posedge core_clk_in)
      begin
        ack_oe_reg <= ack_oe_next;
        irq_oe_reg <= irq_oe_next;
      end

      assign xfer_ack_n_out[b]    = 1'b0;
      assign xfer_ack_n_oe_out[b] = ack_oe_reg;
      assign irq_n_out[b]         = 1'b0;
      assign irq_n_oe_out[b]      = irq_oe_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== fhbp_pkg.sv
// constants of the framer host bus port
// assumes one core clock; all host pins already synchronous to it
`default_nettype none

package fhbp_pkg;

  // =========================================================
  // bus widths
  localparam int ADDR_W       = 12;
  localparam int DATA_W       = 8;
  localparam int BANK_CNT     = 2;
  localparam int MUX_ADDR_LSB = 8;

  // =========================================================
  // variant address widths
  localparam int SEP_ADDR_W_SMALL = 11;
  localparam int SMALL_VARIANT    = 4;
  localparam int TWO_BANK_VARIANT = 16;

  // =========================================================
  // reset values
  localparam logic [ADDR_W-1:0]   ADDR_RST  = 12'h000;
  localparam logic [DATA_W-1:0]   DATA_RST  = 8'h00;
  localparam logic [BANK_CNT-1:0] BANK_IDLE = 2'h3;

  // =========================================================
  // timing
  localparam int CORE_CLK_HZ      = 10_000_000;
  localparam int RST_MIN_PCLK     = 2;

  // =========================================================
  // access sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } fhbp_state_e;

endpackage

`default_nettype wire

// ===== fhbp_host_port_assertions.sv
// checker of the host port pin relations
// bound to fhbp_host_port; one core clock
`timescale 1ns/10ps
`default_nettype none
module fhbp_host_port_assertions
  import fhbp_pkg::*;
(
  input wire logic                core_clk_in,
  input wire logic                rst_in,
  input wire logic                hw_reset_n_in,
  input wire logic                addr_strobe_n_in,
  input wire logic [BANK_CNT-1:0] chip_sel_bank_n_in,
  input wire logic [BANK_CNT-1:0] xfer_ack_n_oe_out,
  input wire logic [BANK_CNT-1:0] irq_pending_in,
  input wire logic [BANK_CNT-1:0] irq_n_oe_out,
  input wire logic                ad_oe_out,
  input wire logic                reg_rd_out,
  input wire logic                reg_wr_out,
  input wire logic                regs_init_out
);
  // ==========================================
  // pin relations
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  AST_ACK_ON:
    assert property (!regs_init_out && !addr_strobe_n_in && !chip_sel_bank_n_in[0]
      |=> xfer_ack_n_oe_out[0]) else $error("ack not driven");
  AST_ACK_OFF:
    assert property (hw_reset_n_in && (addr_strobe_n_in || chip_sel_bank_n_in[0])
      |=> !xfer_ack_n_oe_out[0]) else $error("ack not released");
  AST_ACK_BANK2:
    assert property (!regs_init_out && !addr_strobe_n_in && !chip_sel_bank_n_in[1]
      |=> xfer_ack_n_oe_out[1]) else $error("second ack not driven");
  AST_IRQ:
    assert property (!regs_init_out |=> irq_n_oe_out == $past(irq_pending_in))
      else $error("irq not following pending");
  AST_POR:
    assert property (disable iff (1'b0) rst_in |=> regs_init_out)
      else $error("power-on init missing");
  AST_PIN_INIT:
    assert property (!hw_reset_n_in |=> regs_init_out) else $error("pin init missing");
  AST_INIT_END:
    assert property (!rst_in && hw_reset_n_in |=> !regs_init_out) else $error("init stuck");
  AST_INIT_QUIET:
    assert property (regs_init_out && $past(regs_init_out)
      |-> !ad_oe_out && !reg_rd_out && !reg_wr_out)
      else $error("activity during init");
  AST_RD_DRIVES:
    assert property (reg_rd_out |-> ad_oe_out ##1 !reg_rd_out) else $error("read not driving");
  AST_WR_FLOAT:
    assert property (reg_wr_out |-> !ad_oe_out) else $error("bus driven on write");
  COV_RD: cover property (reg_rd_out);
  COV_WR: cover property (reg_wr_out);
  COV_ACK2: cover property (xfer_ack_n_oe_out[1]);
endmodule
bind fhbp_host_port fhbp_host_port_assertions i_chk (.core_clk_in(core_clk_in),
  .rst_in(rst_in), .hw_reset_n_in(hw_reset_n_in), .addr_strobe_n_in(addr_strobe_n_in),
  .chip_sel_bank_n_in(chip_sel_bank_n_in), .xfer_ack_n_oe_out(xfer_ack_n_oe_out),
  .irq_pending_in(irq_pending_in), .irq_n_oe_out(irq_n_oe_out), .ad_oe_out(ad_oe_out),
  .reg_rd_out(reg_rd_out), .reg_wr_out(reg_wr_out), .regs_init_out(regs_init_out));
`default_nettype wire

// ===== fhbp_host_model.sv
// host processor model driving the parallel port pins
// assumes caller waits for access to return before the next one
`timescale 1ns/10ps
`default_nettype none
module fhbp_host_model
  import fhbp_pkg::*;
(
  input  wire logic                clk_in,
  output var  logic                as_n_out,
  output var  logic                ds_n_out,
  output var  logic                dir_n_out,
  output var  logic [BANK_CNT-1:0] cs_n_out,
  output var  logic [ADDR_W-1:0]   addr_out,
  output var  logic [DATA_W-1:0]   ad_out
);
  initial
  begin
    {as_n_out, ds_n_out, dir_n_out, cs_n_out} = 5'h1f;
    addr_out = 12'h000;
    ad_out = 8'h00;
  end
  task automatic access(input logic mux, input logic wr, input logic bnk,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    addr_out <= mux ? {a[11:8], ~a[7:0]} : a;
    ad_out <= mux ? a[7:0] : d;
    cs_n_out <= bnk ? 2'h1 : 2'h2;
    as_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    ad_out <= d;
    ds_n_out <= mux & wr;
    dir_n_out <= !wr;
    repeat (8) @(posedge clk_in);
    {as_n_out, ds_n_out, dir_n_out} <= 3'h7;
    @(posedge clk_in);
    cs_n_out <= 2'h3;
    addr_out <= ~addr_out;
    ad_out <= ~ad_out;
    repeat (6) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ===== framer_host_bus_port_tb_top.sv
// self-checking bench of the host port against a queue model
// assumes fhbp_host_model as host and bench as register file
`timescale 1ns/10ps
`default_nettype none
module framer_host_bus_port_tb_top
  import fhbp_pkg::*;
;
  logic core_clk_in, rst_in, hw_n, pclk, ts, bs, as_n, ds_n, dir_n;
  logic [BANK_CNT-1:0] cs_n, ack, ack_oe, irq, irq_n, irq_oe;
  logic [ADDR_W-1:0] addr, r_addr;
  logic [DATA_W-1:0] h_ad, ad_in, ad_o, wdata, rdata;
  logic ad_oe, bank, wr_p, rd_p, init;
  logic [1:0] rd_dly;
  logic [24:0] q[$];
  logic [24:0] e;
  int fail_count, cmp_count, cyc, i;
  logic wr, bnk;
  logic [11:0] a;
  logic [7:0] d;
  assign ad_in = ad_oe ? ad_o : h_ad;
  fhbp_host_port #(.FRAMER_COUNT(16)) i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .hw_reset_n_in(hw_n), .proc_sample_clk_in(pclk), .timing_select_in(ts),
    .bus_style_select_in(bs), .addr_pins_in(addr), .ad_in(ad_in), .ad_out(ad_o),
    .ad_oe_out(ad_oe), .addr_strobe_n_in(as_n), .data_or_read_strobe_n_in(ds_n),
    .dir_or_write_strobe_n_in(dir_n), .chip_sel_bank_n_in(cs_n), .xfer_ack_n_out(ack),
    .xfer_ack_n_oe_out(ack_oe), .irq_pending_in(irq), .irq_n_out(irq_n),
    .irq_n_oe_out(irq_oe), .reg_addr_out(r_addr), .reg_bank_out(bank),
    .reg_wdata_out(wdata), .reg_wr_out(wr_p), .reg_rd_out(rd_p), .reg_rdata_in(rdata),
    .regs_init_out(init));
  fhbp_host_model i_host (.clk_in(core_clk_in), .as_n_out(as_n), .ds_n_out(ds_n),
    .dir_n_out(dir_n), .cs_n_out(cs_n), .addr_out(addr), .ad_out(h_ad));
  // ==========================================
  // checking and closing
  task automatic chk(input string n, input logic [11:0] ex, input logic [11:0] got);
    cmp_count++;
    if (got !== ex)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in)
  begin
    cyc++;
    pclk <= cyc[1];
    irq <= 2'($urandom);
    rd_dly <= {rd_dly[0], rd_p === 1'b1};
    if (rd_dly[1])
    begin
      chk("read data", {4'h1, rdata}, {3'h0, ad_oe, ad_o});
      chk("ack", {10'h0, e[20], ~e[20]}, {10'h0, ack_oe});
      chk("open drain level", 12'h0, {8'h0, ack, irq_n});
    end
    if (wr_p === 1'b1 || rd_p === 1'b1)
    begin
      e = (q.size() > 0) ? q.pop_front() : 25'h1ff_ffff;
      chk("address", e[19:8], r_addr);
      chk("bank", {11'h0, e[20]}, {11'h0, bank});
      chk("write", {11'h0, e[21]}, {11'h0, wr_p});
      if (e[21])
        chk("write data", {4'h0, e[7:0]}, {4'h0, wdata});
    end
    if (cyc == 3000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    rst_in = 1'b1;
    hw_n = 1'b1;
    ts = 1'b0;
    bs = 1'b0;
    rdata = 8'h00;
    void'($urandom(32'hd758));
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    for (i = 0; i < 24; i++)
    begin
      wr = i[2];
      bnk = 1'($urandom);
      a = 12'($urandom);
      d = 8'($urandom);
      ts <= i[1];
      bs <= i[0];
      rdata <= 8'($urandom);
      q.push_back({3'h0, wr, bnk, a, d});
      i_host.access(i[0], wr, bnk, a, d);
      if (i == 11)
      begin
        hw_n <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        chk("init", 12'h1, {11'h0, init});
        hw_n <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        chk("init end", 12'h0, {11'h0, init});
      end
    end
    chk("pending", 12'h0, 12'(q.size()));
    conclude();
  end
endmodule
`default_nettype wire
